// ---- rr_exec_map.svh ----
// register offsets, field positions, reset values and timing counts for the return/rotate unit
`ifndef RR_EXEC_MAP_SVH
`define RR_EXEC_MAP_SVH

// ----------------------------------------
// opcode patterns, instruction field bits and file address limits
// ----------------------------------------
`define RR_RET_MASK 16'hFFFE
`define RR_RET_CODE 16'h0012
`define RR_ROT_MASK 16'hFC00
`define RR_ROT_CODE 16'h3400
`define RR_BIT_SHADOW 0
`define RR_BIT_DEST 9
`define RR_BIT_BANK 8
`define RR_ILO_LIMIT 8'h5F
`define RR_ACCESS_SPLIT 8'h80
`define RR_ACCESS_HIGH 4'hF

// ----------------------------------------
// flag positions
// ----------------------------------------
`define RR_FLAG_C 0
`define RR_FLAG_Z 2
`define RR_FLAG_N 4

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RR_OFS_CTRL 8'h00
`define RR_OFS_WORK 8'h04
`define RR_OFS_FLAGS 8'h08
`define RR_OFS_BANK 8'h0C
`define RR_OFS_PCU 8'h10
`define RR_OFS_PCH 8'h14
`define RR_OFS_PC 8'h18
`define RR_OFS_STATE 8'h1C

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RR_RST_CTRL 2'h0
`define RR_RST_BYTE 8'h00
`define RR_RST_BANK 4'h0
`define RR_RST_PC 21'h000000
`define RR_PC_STEP 21'h000002
`define RR_QDIV 8
`define RR_RET_CYCLES 2

`endif

// ---- rr_exec_pkg.sv ----
// types shared by the return/rotate unit
package rr_exec_pkg;
   typedef enum {RR_Q1, RR_Q2, RR_Q3, RR_Q4} rr_qphase_t;
   typedef enum {RR_OP_NONE, RR_OP_RET, RR_OP_ROT} rr_op_t;
endpackage

// ---- rr_rotate.sv ----
// rotate-left-through-carry datapath with flag results
`timescale 1ns/1ps
`include "rr_exec_map.svh"
module rr_rotate
   import rr_exec_pkg::*;
(
   input wire logic [7:0] operand,
   input wire logic carryIn,
   output logic [7:0] result,
   output logic carryOut,
   output logic negOut,
   output logic zeroOut
);
   always_comb begin
      result = {operand[6:0], carryIn};
      carryOut = operand[7];
      negOut = result[7];
      zeroOut = (result == 8'h00);
   end
endmodule

// ---- rr_exec.sv ----
// return-from-subroutine and rotate-left-through-carry execution unit with apb registers
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "rr_exec_map.svh"
module rr_exec
   import rr_exec_pkg::*;
#(
   parameter int QDIV = `RR_QDIV
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] instrWord,
   input wire logic instrValid,
   output logic instrTaken,
   input wire logic [20:0] stackTopValue,
   output logic stackPop,
   input wire logic [7:0] shadowWorkingReg,
   input wire logic [7:0] shadowFlagsReg,
   input wire logic [3:0] shadowBankSelect,
   input wire logic [11:0] indexBase,
   output logic [11:0] memAddr,
   output logic memRdEn,
   input wire logic [7:0] memRdData,
   output logic memWrEn,
   output logic [7:0] memWrData,
   output logic [20:0] progCounter,
   output logic [7:0] workingReg,
   output logic [7:0] flagsReg,
   output logic [3:0] bankSelectReg,
   output logic flushing
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic regKnown(input logic [7:0] a);
      logic ok;
      ok = 1'b0;
      unique case (a)
         `RR_OFS_CTRL, `RR_OFS_WORK, `RR_OFS_FLAGS, `RR_OFS_BANK,
         `RR_OFS_PCU, `RR_OFS_PCH, `RR_OFS_PC, `RR_OFS_STATE: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   function automatic logic [11:0] effAddr(input logic [7:0] f, input logic bankBit, input logic ext,
                                           input logic [3:0] bank_select_reg, input logic [11:0] base);
      logic [11:0] a;
      a = 12'h000;
      if (bankBit) begin
         a = {bank_select_reg, f};
      end else if (ext && (f <= `RR_ILO_LIMIT)) begin
         a = base + {4'h0, f};
      end else if (f < `RR_ACCESS_SPLIT) begin
         a = {4'h0, f};
      end else begin
         a = {`RR_ACCESS_HIGH, f};
      end
      return a;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] divCnt_q, divCnt_d;
   logic qTick;
   rr_qphase_t phase_q, phase_d;
   rr_op_t op_q, op_d;
   logic [15:0] instr_q, instr_d;
   logic flush_q, flush_d;
   logic taken_q, taken_d;
   logic [7:0] operand_q, operand_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic [7:0] work_q, work_d;
   logic [7:0] flags_q, flags_d;
   logic [3:0] bank_q, bank_d;
   logic [7:0] pcu_q, pcu_d;
   logic [7:0] pch_q, pch_d;
   logic [20:0] pc_q, pc_d;
   logic [11:0] memAddr_q, memAddr_d;
   logic memRdEn_q, memRdEn_d;
   logic memWrEn_q, memWrEn_d;
   logic [7:0] memWrData_q, memWrData_d;
   logic stackPop_q, stackPop_d;
   logic instrTaken_q, instrTaken_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [7:0] rotResult;
   logic rotCarry, rotNeg, rotZero;
   logic apbWrite, apbSetup, hwWork, hwFlags, hwBank;
   logic busWork, busFlags, busBank;

   rr_rotate u_rotate (
      .operand(operand_q),
      .carryIn(flags_q[`RR_FLAG_C]),
      .result(rotResult),
      .carryOut(rotCarry),
      .negOut(rotNeg),
      .zeroOut(rotZero)
   );

   assign qTick = (divCnt_q == 8'(QDIV - 1));
   assign apbSetup = psel && penable && !pready_q;
   assign apbWrite = psel && penable && pready_q && pwrite;

   // ----------------------------------------
   // bus write strobes
   // ----------------------------------------
   assign busWork = apbWrite && (paddr == `RR_OFS_WORK);
   assign busFlags = apbWrite && (paddr == `RR_OFS_FLAGS);
   assign busBank = apbWrite && (paddr == `RR_OFS_BANK);

   // ----------------------------------------
   // quarter-cycle sequencer and execution
   // ----------------------------------------
   always_comb begin
      divCnt_d = qTick ? 8'h00 : divCnt_q + 8'h01;
      phase_d = phase_q;
      op_d = op_q;
      instr_d = instr_q;
      flush_d = flush_q;
      taken_d = taken_q;
      operand_d = operand_q;
      work_d = work_q;
      flags_d = flags_q;
      bank_d = bank_q;
      pc_d = pc_q;
      memAddr_d = memAddr_q;
      memRdEn_d = 1'b0;
      memWrEn_d = 1'b0;
      memWrData_d = memWrData_q;
      stackPop_d = 1'b0;
      instrTaken_d = 1'b0;
      hwWork = 1'b0;
      hwFlags = 1'b0;
      hwBank = 1'b0;
      if (qTick) begin
         unique case (phase_q)
            RR_Q1: begin
               phase_d = RR_Q2;
               op_d = RR_OP_NONE;
               taken_d = 1'b0;
               if (flush_q) begin
                  flush_d = 1'b0;
               end else if (instrValid && ctrl_q[1]) begin
                  instr_d = instrWord;
                  taken_d = 1'b1;
                  instrTaken_d = 1'b1;
                  if ((instrWord & `RR_RET_MASK) == `RR_RET_CODE) begin
                     op_d = RR_OP_RET;
                  end else if ((instrWord & `RR_ROT_MASK) == `RR_ROT_CODE) begin
                     op_d = RR_OP_ROT;
                  end
               end
            end
            RR_Q2: begin
               phase_d = RR_Q3;
               if (op_q == RR_OP_ROT) begin
                  memAddr_d = effAddr(instr_q[7:0], instr_q[`RR_BIT_BANK], ctrl_q[0], bank_q, indexBase);
                  memRdEn_d = 1'b1;
               end
            end
            RR_Q3: begin
               phase_d = RR_Q4;
               if (op_q == RR_OP_ROT) begin
                  // read data must be settled by this tick, one quarter after the read strobe
                  operand_d = memRdData;
               end
            end
            RR_Q4: begin
               phase_d = RR_Q1;
               if (op_q == RR_OP_RET) begin
                  pc_d = stackTopValue;
                  stackPop_d = 1'b1;
                  flush_d = 1'b1;
                  if (instr_q[`RR_BIT_SHADOW]) begin
                     work_d = shadowWorkingReg;
                     flags_d = shadowFlagsReg;
                     bank_d = shadowBankSelect;
                     hwWork = 1'b1;
                     hwFlags = 1'b1;
                     hwBank = 1'b1;
                  end
               end else if (op_q == RR_OP_ROT) begin
                  pc_d = pc_q + `RR_PC_STEP;
                  if (instr_q[`RR_BIT_DEST]) begin
                     memWrEn_d = 1'b1;
                     memWrData_d = rotResult;
                  end else begin
                     work_d = rotResult;
                     hwWork = 1'b1;
                  end
                  flags_d[`RR_FLAG_C] = rotCarry;
                  flags_d[`RR_FLAG_N] = rotNeg;
                  flags_d[`RR_FLAG_Z] = rotZero;
                  hwFlags = 1'b1;
               end else if (taken_q) begin
                  // other opcodes run as no-ops here, only the counter moves
                  pc_d = pc_q + `RR_PC_STEP;
               end
            end
         endcase
      end
      // the core's own update wins over a bus write in the same cycle
      if (busWork && !hwWork) begin
         work_d = pwdata[7:0];
      end
      if (busFlags && !hwFlags) begin
         flags_d = pwdata[7:0];
      end
      if (busBank && !hwBank) begin
         bank_d = pwdata[3:0];
      end
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // one wait state: the answer is registered so every bus output is a flop
   always_comb begin
      ctrl_d = ctrl_q;
      pcu_d = pcu_q;
      pch_d = pch_q;
      pready_d = apbSetup;
      pslverr_d = apbSetup && !regKnown(paddr);
      prdata_d = prdata_q;
      if (apbSetup) begin
         prdata_d = 32'h00000000;
         if (!pwrite) begin
            unique case (paddr)
               `RR_OFS_CTRL: prdata_d = {30'h00000000, ctrl_q};
               `RR_OFS_WORK: prdata_d = {24'h000000, work_q};
               `RR_OFS_FLAGS: prdata_d = {24'h000000, flags_q};
               `RR_OFS_BANK: prdata_d = {28'h0000000, bank_q};
               `RR_OFS_PCU: prdata_d = {24'h000000, pcu_q};
               `RR_OFS_PCH: prdata_d = {24'h000000, pch_q};
               `RR_OFS_PC: prdata_d = {11'h000, pc_q};
               `RR_OFS_STATE: prdata_d = {28'h0000000, flush_q, op_q == RR_OP_ROT, op_q == RR_OP_RET, taken_q};
               default: prdata_d = 32'h00000000;
            endcase
         end
      end
      if (apbWrite) begin
         unique case (paddr)
            `RR_OFS_CTRL: ctrl_d = pwdata[1:0];
            `RR_OFS_PCU: pcu_d = pwdata[7:0];
            `RR_OFS_PCH: pch_d = pwdata[7:0];
            default: ctrl_d = ctrl_q;
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         divCnt_q <= 8'h00;
         phase_q <= RR_Q1;
         op_q <= RR_OP_NONE;
         instr_q <= 16'h0000;
         flush_q <= 1'b0;
         taken_q <= 1'b0;
         operand_q <= `RR_RST_BYTE;
         ctrl_q <= `RR_RST_CTRL;
         work_q <= `RR_RST_BYTE;
         flags_q <= `RR_RST_BYTE;
         bank_q <= `RR_RST_BANK;
         pcu_q <= `RR_RST_BYTE;
         pch_q <= `RR_RST_BYTE;
         pc_q <= `RR_RST_PC;
         memAddr_q <= 12'h000;
         memRdEn_q <= 1'b0;
         memWrEn_q <= 1'b0;
         memWrData_q <= `RR_RST_BYTE;
         stackPop_q <= 1'b0;
         instrTaken_q <= 1'b0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         divCnt_q <= divCnt_d;
         phase_q <= phase_d;
         op_q <= op_d;
         instr_q <= instr_d;
         flush_q <= flush_d;
         taken_q <= taken_d;
         operand_q <= operand_d;
         ctrl_q <= ctrl_d;
         work_q <= work_d;
         flags_q <= flags_d;
         bank_q <= bank_d;
         pcu_q <= pcu_d;
         pch_q <= pch_d;
         pc_q <= pc_d;
         memAddr_q <= memAddr_d;
         memRdEn_q <= memRdEn_d;
         memWrEn_q <= memWrEn_d;
         memWrData_q <= memWrData_d;
         stackPop_q <= stackPop_d;
         instrTaken_q <= instrTaken_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign instrTaken = instrTaken_q;
   assign stackPop = stackPop_q;
   assign memAddr = memAddr_q;
   assign memRdEn = memRdEn_q;
   assign memWrEn = memWrEn_q;
   assign memWrData = memWrData_q;
   assign progCounter = pc_q;
   assign workingReg = work_q;
   assign flagsReg = flags_q;
   assign bankSelectReg = bank_q;
   assign flushing = flush_q;
endmodule

// ---- rr_exec_asserts.sv ----
// assertion checker for the return/rotate unit
`timescale 1ns/1ps
`include "rr_exec_map.svh"
module rr_exec_asserts
   import rr_exec_pkg::*;
#(
   parameter int QDIV = 8
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] instrWord,
   input wire logic instrTaken,
   input wire logic [20:0] stackTopValue,
   input wire logic stackPop,
   input wire logic [7:0] shadowWorkingReg,
   input wire logic [7:0] shadowFlagsReg,
   input wire logic [3:0] shadowBankSelect,
   input wire logic [11:0] memAddr,
   input wire logic memRdEn,
   input wire logic memWrEn,
   input wire logic [7:0] memWrData,
   input wire logic [20:0] progCounter,
   input wire logic [7:0] workingReg,
   input wire logic [7:0] flagsReg,
   input wire logic [3:0] bankSelectReg
);
   // ----------------------------------------
   // opcode tracking
   // ----------------------------------------
   localparam int RDGAP = 2 * QDIV;
   logic [15:0] lastWord_q;
   logic [15:0] lastWord_d;
   logic isRot;
   // late pulses are tied back to the word that caused them
   always_comb begin
      lastWord_d = instrTaken ? instrWord : lastWord_q;
   end
   always_ff @(posedge clk) begin
      lastWord_q <= reset ? 16'h0000 : lastWord_d;
   end
   assign isRot = (lastWord_q & `RR_ROT_MASK) == `RR_ROT_CODE;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_pop_ret_only: assert property (
      stackPop |-> (lastWord_q & `RR_RET_MASK) == `RR_RET_CODE) else $error("pop without return");
   a_ret_pop_pc: assert property (
      stackPop |-> progCounter == $past(stackTopValue)) else $error("pc not from stack");
   a_ret_shadow: assert property (
      stackPop && lastWord_q[0] |-> workingReg == $past(shadowWorkingReg) && flagsReg == $past(shadowFlagsReg)
      && bankSelectReg == $past(shadowBankSelect)) else $error("shadows not restored");
   a_ret_keep: assert property (
      stackPop && !lastWord_q[0] |-> $stable(workingReg) && $stable(flagsReg) && $stable(bankSelectReg))
      else $error("return changed regs");
   a_flush_no_take: assert property (
      stackPop |-> ##1 !instrTaken [*4]) else $error("take during flush");
   a_bank_addr: assert property (
      memRdEn && isRot && lastWord_q[`RR_BIT_BANK] |-> memAddr == {bankSelectReg, lastWord_q[7:0]})
      else $error("bank address wrong");
   a_wr_dest: assert property (
      memWrEn |-> isRot && lastWord_q[`RR_BIT_DEST]) else $error("stray file write");
   a_rd_wr_gap: assert property (
      memWrEn |-> $past(memRdEn, RDGAP)) else $error("write not two quarters after read");
   a_rot_flags: assert property (
      memWrEn |-> flagsReg[`RR_FLAG_N] == memWrData[7] && flagsReg[`RR_FLAG_Z] == (memWrData == 8'h00))
      else $error("n or z flag wrong");
   a_apb_wait: assert property (
      psel && penable && !pready |=> pready) else $error("bus answer late");
endmodule

bind rr_exec rr_exec_asserts #(.QDIV(QDIV)) rr_exec_asserts_i (.clk, .reset, .psel, .penable, .pready, .pslverr,
   .instrWord, .instrTaken, .stackTopValue, .stackPop, .shadowWorkingReg, .shadowFlagsReg, .shadowBankSelect,
   .memAddr, .memRdEn, .memWrEn, .memWrData, .progCounter, .workingReg, .flagsReg, .bankSelectReg);

// ---- testbench.sv ----
// self-checking bench for the return/rotate unit
`timescale 1ns/1ps
`include "rr_exec_map.svh"
module testbench;
   // ----------------------------------------
   // stimulus and scenarios
   // ----------------------------------------
   localparam int QD = 2;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, instrValid = 0, expC = 1;
   logic [7:0] paddr = 0, memRdData = 0, shadowWorkingReg = 8'h5A, shadowFlagsReg = 8'h15;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] instrWord = 0;
   logic [20:0] stackTopValue = 21'h01ABCE, progCounter, expPc = 0;
   logic [3:0] shadowBankSelect = 4'h9, bankSelectReg, expB = 4'h5;
   logic [11:0] indexBase = 12'h100, memAddr, rdAddr;
   logic [7:0] memWrData, workingReg, flagsReg, wrData, expW = 8'h3C;
   logic pready, pslverr, instrTaken, stackPop, memRdEn, memWrEn, flushing, er;
   int errorCnt = 0, checked = 0, pops = 0, wrs = 0, fls = 0;
   rr_exec #(.QDIV(QD)) rr_exec_i (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .instrWord, .instrValid, .instrTaken, .stackTopValue, .stackPop, .shadowWorkingReg,
      .shadowFlagsReg, .shadowBankSelect, .indexBase, .memAddr, .memRdEn, .memRdData, .memWrEn, .memWrData,
      .progCounter, .workingReg, .flagsReg, .bankSelectReg, .flushing);
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (stackPop === 1'b1) pops++;
      if (flushing === 1'b1) fls++;
      if (memRdEn === 1'b1) rdAddr = memAddr;
      if (memWrEn === 1'b1) begin
         wrs++;
         wrData = memWrData;
      end
   end
   task automatic wrap_up();
      if (errorCnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         errorCnt++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   // bounded waits only, a hang ends the run
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 20) begin
         check(0, "bus hang");
         wrap_up();
      end
      @(posedge clk);
   endtask
   task automatic exec(input logic [15:0] w);
      int n;
      instrWord <= w;
      instrValid <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (instrTaken !== 1'b1 && n < 40);
      instrValid <= 0;
      if (n >= 40) begin
         check(0, "word not taken");
         wrap_up();
      end
      repeat (12 * QD) @(posedge clk);
   endtask
   task automatic rot(input logic [15:0] w, input logic [7:0] din, input logic [11:0] ea);
      logic [7:0] r;
      int p;
      r = {din[6:0], expC};
      p = wrs;
      memRdData <= din;
      exec(w);
      check(rdAddr === ea, "rotate address");
      check((wrs == p + 1) === w[`RR_BIT_DEST], "write strobe");
      if (w[`RR_BIT_DEST]) check(wrData === r, "file data");
      else expW = r;
      check(workingReg === expW, "working reg");
      check(flagsReg[`RR_FLAG_C] === din[7] && flagsReg[`RR_FLAG_N] === r[7], "carry or n");
      check(flagsReg[`RR_FLAG_Z] === (r == 8'h00), "zero flag");
      expC = din[7];
      expPc += 2;
      check(progCounter === expPc, "pc step");
   endtask
   task automatic ret(input logic s);
      int p;
      int f;
      p = pops;
      f = fls;
      exec({15'h0009, s});
      check(pops == p + 1 && progCounter === 21'h01ABCE, "return pc");
      check(fls > f, "no flush");
      if (s) check(workingReg === 8'h5A && flagsReg === 8'h15 && bankSelectReg === 4'h9, "restore");
      else check(workingReg === expW && bankSelectReg === expB && flagsReg[0] === expC, "kept");
      expPc = 21'h01ABCE;
   endtask
   task automatic scn_bus();
      apb(1, `RR_OFS_CTRL, 32'h2);
      apb(0, `RR_OFS_CTRL, 0);
      check(rd === 32'h2 && er === 1'b0, "ctrl readback");
      apb(0, 8'h40, 0);
      check(er === 1'b1 && rd === 32'h0, "unmapped");
      apb(1, `RR_OFS_WORK, 32'h3C);
      apb(1, `RR_OFS_FLAGS, 32'h1);
      apb(1, `RR_OFS_BANK, 32'h5);
      apb(1, `RR_OFS_PCU, 32'h0A);
      apb(1, `RR_OFS_PCH, 32'h0B);
   endtask
   task automatic scn_rot();
      rot(16'h3512, 8'hE6, 12'h512);
      rot(16'h3660, 8'h00, 12'h060);
      rot(16'h3680, 8'h80, 12'hF80);
      rot(16'h345F, 8'h40, 12'h05F);
      apb(1, `RR_OFS_CTRL, 32'h3);
      rot(16'h345F, 8'h01, 12'h15F);
      rot(16'h3460, 8'h7F, 12'h060);
   endtask
   task automatic scn_ret();
      int p;
      p = pops;
      exec(16'h0010);
      expPc += 2;
      check(pops == p && progCounter === expPc, "not a return");
      ret(0);
      ret(1);
      apb(0, `RR_OFS_PCU, 0);
      check(rd === 32'h0A, "upper latch");
      apb(0, `RR_OFS_PCH, 0);
      check(rd === 32'h0B, "high latch");
      apb(0, `RR_OFS_PC, 0);
      check(rd === 32'h0001ABCE, "pc readback");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      scn_bus();
      scn_rot();
      scn_ret();
      wrap_up();
   end
endmodule
